// >>> siep_pkg.sv
// Package of constants for the switch internal error protection block
// Operation
// - Internal errors reported through this port's error reporting only while enable bit set.
// - With reporting disabled, the four error reporting mask and severity fields are read-only.
// - Uncorrectable internal error report logs an all-ones header instead of the real one.
// - One internal error status bit per source, set when that error is detected.
// - A set mask bit stops its status bit from generating an internal error report.
// - Severity bit picks uncorrectable or correctable report for an unmasked error.
// - Each report sets the matching uncorrectable or correctable error reporting status bit.
// - Writing one to a test bit sets that status bit, handled like a real error.
// - Core discards packets older than 64 seconds at head of ingress or egress queue.
// - Core time-out during a broadcast packet aborts it, possibly partly sent.
// - Memories use SECDED: single errors corrected, both kinds reported only when enabled.
// - A double-bit error does not disable single-bit correction of the word.
// - Five protected memories per port, each with its own status bit.
// - Double-bit error in buffer data nullifies the packet: inverted CRC, EDB end.
// - No replay with a new sequence number; double-bit error during replay flushes buffer.
// - Double-bit error on a packet for the switch's own function discards it.
// - Ingress checks link CRC, computes 32-bit DWord even parity; CRC failure relies on retry.
// - Parity is updated incrementally when packet data changes, never regenerated.
// - Egress checks parity alongside outgoing CRC; CRC trusted only without parity error.
// - Egress parity error nullifies packet and sets the end-to-end parity error status bit.
// - Parity error during replay flushes all packets from the replay buffer.
// - Own packets get parity on generation; consumed ones checked, discarded, status set.
package siep_pkg;
   // Status bit positions
   localparam int SIEP_NSRC         = 7;
   localparam int SIEP_BIT_IBCTL    = 0;
   localparam int SIEP_BIT_IBDATA   = 1;
   localparam int SIEP_BIT_EBCTL    = 2;
   localparam int SIEP_BIT_EBDATA   = 3;
   localparam int SIEP_BIT_RBCTL    = 4;
   localparam int SIEP_BIT_TIMEOUT  = 5;
   localparam int SIEP_BIT_END_TO_END_PARITY_ERROR    = 6;
   localparam int SIEP_NMEM         = 5;
   localparam logic [SIEP_NSRC-1:0] SIEP_MASK_RST = 7'h00;
   localparam logic [SIEP_NSRC-1:0] SIEP_SEV_RST  = 7'h78;
   // Age limit in seconds and a default tick rate of the age clock
   localparam int SIEP_AGE_LIMIT_S  = 64;
   localparam int SIEP_CLK_HZ       = 50000000;
   localparam longint SIEP_AGE_CYC  = longint'(SIEP_AGE_LIMIT_S) * longint'(SIEP_CLK_HZ);
   localparam logic [31:0] SIEP_HDR_ONES = 32'hffffffff;
   // SECDED code geometry for a 32-bit data word
   localparam int SIEP_DW  = 32;
   localparam int SIEP_CW  = 7;
endpackage : siep_pkg

// >>> siep_ecc_if.sv
// Interface carrying one memory word check between top and SECDED decoder
`timescale 1ns/10ps
`default_nettype none
interface siep_ecc_if;
   logic [31:0] raw_data;
   logic [6:0]  raw_check;
   logic        rd_valid;
   logic [31:0] fixed_data;
   logic        single_err;
   logic        double_err;
   modport top (output raw_data, output raw_check, output rd_valid,
                input fixed_data, input single_err, input double_err);
   modport dec (input raw_data, input raw_check, input rd_valid,
                output fixed_data, output single_err, output double_err);
endinterface : siep_ecc_if
`default_nettype wire

// >>> siep_secded.sv
// SECDED decoder for a 32-bit word with 6 Hamming bits and overall parity
`timescale 1ns/10ps
`default_nettype none
module siep_secded
   import siep_pkg::*;
(
   siep_ecc_if.dec e
);
   function automatic logic [5:0] siep_syn(input logic [31:0] d, input logic [5:0] c);
      logic [5:0] s;
      logic [5:0] pos;
      s = c;
      pos = 6'h00;
      for (int i = 0, p = 1; i < 32; p++) begin
         if ((p & (p - 1)) != 0) begin
            pos = 6'(p);
            if (d[i]) begin
               s = s ^ pos;
            end
            i++;
         end
      end
      return s;
   endfunction : siep_syn

   logic [5:0]  syn;
   logic        ovr;
   logic [31:0] flip;

   always_comb begin
      syn  = siep_syn(e.raw_data, e.raw_check[5:0]);
      ovr  = ^{e.raw_data, e.raw_check};
      flip = 32'h00000000;
      for (int i = 0, p = 1; i < 32; p++) begin
         if ((p & (p - 1)) != 0) begin
            // Correction acts on any syndrome that names a data bit, also under a double error
            if (syn == 6'(p) && syn != 6'h00) begin
               flip[i] = 1'b1;
            end
            i++;
         end
      end
   end

   assign e.fixed_data = e.raw_data ^ flip;
   assign e.single_err = e.rd_valid && ovr;
   assign e.double_err = e.rd_valid && !ovr && (syn != 6'h00);
endmodule : siep_secded
`default_nettype wire

// >>> siep_top.sv
// Per-port internal error detection, status and reporting
`timescale 1ns/10ps
`default_nettype none
module siep_top
   import siep_pkg::*;
#(
   parameter longint AGE_CYCLES = SIEP_AGE_CYC,
   parameter int     AGE_W      = 40
)(
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   input  wire logic                  REPORT_ENABLE,
   input  wire logic                  MASK_WR,
   input  wire logic [SIEP_NSRC-1:0]  MASK_WDATA,
   input  wire logic                  SEV_WR,
   input  wire logic [SIEP_NSRC-1:0]  SEV_WDATA,
   input  wire logic                  STATUS_CLR_WR,
   input  wire logic [SIEP_NSRC-1:0]  STATUS_CLR_DATA,
   input  wire logic                  TEST_WR,
   input  wire logic [SIEP_NSRC-1:0]  TEST_DATA,
   input  wire logic                  AER_WR,
   input  wire logic [3:0]            AER_WDATA,
   input  wire logic [2:0]            MEM_SEL,
   input  wire logic                  MEM_RD_VALID,
   input  wire logic [31:0]           MEM_RD_DATA,
   input  wire logic [6:0]            MEM_RD_CHECK,
   input  wire logic                  MEM_SELF_TARGET,
   input  wire logic                  HEAD_VALID,
   input  wire logic [AGE_W-1:0]      HEAD_AGE,
   input  wire logic                  HEAD_BROADCAST,
   input  wire logic                  ING_VALID,
   input  wire logic [31:0]           ING_DATA,
   input  wire logic                  ING_LAST,
   input  wire logic                  ING_LCRC_OK,
   input  wire logic                  EGR_VALID,
   input  wire logic [31:0]           EGR_DATA,
   input  wire logic                  EGR_PAR,
   input  wire logic                  EGR_LAST,
   input  wire logic                  EGR_REPLAY,
   input  wire logic                  EGR_CONSUME,
   input  wire logic                  MOD_VALID,
   input  wire logic [31:0]           MOD_OLD,
   input  wire logic [31:0]           MOD_NEW,
   input  wire logic                  MOD_PAR_IN,
   output logic                       ING_PAR,
   output logic                       ING_NAK,
   output logic                       MOD_PAR_OUT,
   output logic [31:0]                MEM_FIXED_DATA,
   output logic                       HEAD_DISCARD,
   output logic                       BCAST_ABORT,
   output logic                       EGR_NULLIFY,
   output logic                       EGR_CRC_INVERT,
   output logic                       EGR_END_EDB,
   output logic                       REPLAY_FLUSH,
   output logic                       CONSUME_DISCARD,
   output logic [SIEP_NSRC-1:0]       STATUS,
   output logic [SIEP_NSRC-1:0]       MASK,
   output logic [SIEP_NSRC-1:0]       SEVERITY,
   output logic [3:0]                 AER_FIELDS,
   output logic                       AER_UNCOR_STATUS,
   output logic                       AER_COR_STATUS,
   output logic                       AER_HDR_LOG_VALID,
   output logic [31:0]                AER_HDR_LOG
);
   typedef struct packed {
      logic [SIEP_NSRC-1:0] status;
      logic [SIEP_NSRC-1:0] mask;
      logic [SIEP_NSRC-1:0] sev;
      logic [3:0]           aer_fields;
      logic                 uncor;
      logic                 cor;
      logic                 hdr_valid;
      logic [31:0]          hdr;
      logic                 ing_par;
      logic                 ing_nak;
      logic                 mod_par;
      logic [31:0]          mem_fixed;
      logic                 head_discard;
      logic                 bcast_abort;
      logic                 pkt_bad;
      logic                 nullify;
      logic                 flush;
      logic                 consume_discard;
   } siep_state_t;

   siep_state_t st_reg;
   siep_state_t st_next;

   siep_ecc_if ecc ();
   siep_secded u_dec (.e(ecc));

   assign ecc.raw_data  = MEM_RD_DATA;
   assign ecc.raw_check = MEM_RD_CHECK;
   assign ecc.rd_valid  = MEM_RD_VALID;

   // Even parity: the dword and its parity bit together hold an even count of ones
   function automatic logic siep_par(input logic [31:0] d);
      return ^d;
   endfunction : siep_par

   logic [SIEP_NSRC-1:0] detect;
   logic [SIEP_NSRC-1:0] newly;
   logic                 mem_any;
   logic                 mem_dbl;
   logic                 timeout;
   logic                 egr_perr;
   logic                 cur_bad;

   always_comb begin
      st_next = st_reg;
      detect  = '0;
      mem_any = ecc.single_err || ecc.double_err;
      mem_dbl = ecc.double_err;
      if (mem_any && MEM_SEL < 3'(SIEP_NMEM)) begin
         detect[MEM_SEL] = 1'b1;
      end
      timeout = HEAD_VALID && (HEAD_AGE > AGE_W'(AGE_CYCLES));
      detect[SIEP_BIT_TIMEOUT] = timeout;
      egr_perr = EGR_VALID && (siep_par(EGR_DATA) != EGR_PAR);
      detect[SIEP_BIT_END_TO_END_PARITY_ERROR] = egr_perr;

      // Hardware sets and test writes win over software clears
      newly = detect | (TEST_WR ? TEST_DATA : '0);
      st_next.status = (st_reg.status & ~(STATUS_CLR_WR ? STATUS_CLR_DATA : '0)) | newly;

      if (!REPORT_ENABLE) begin
         st_next.aer_fields = st_reg.aer_fields;
      end else if (AER_WR) begin
         st_next.aer_fields = AER_WDATA;
      end
      if (MASK_WR) begin
         st_next.mask = MASK_WDATA;
      end
      if (SEV_WR) begin
         st_next.sev = SEV_WDATA;
      end

      newly = newly & ~st_reg.mask;
      st_next.uncor     = 1'b0;
      st_next.cor       = 1'b0;
      st_next.hdr_valid = 1'b0;
      if (REPORT_ENABLE && newly != '0) begin
         st_next.uncor = |(newly & st_reg.sev);
         st_next.cor   = |(newly & ~st_reg.sev);
         if (|(newly & st_reg.sev)) begin
            st_next.hdr_valid = 1'b1;
            st_next.hdr       = SIEP_HDR_ONES;
         end
      end

      // Ingress parity generation and CRC retry
      st_next.ing_par = ING_VALID ? siep_par(ING_DATA) : st_reg.ing_par;
      st_next.ing_nak = ING_VALID && ING_LAST && !ING_LCRC_OK;
      // Parity adjusted by the changed bits only
      st_next.mod_par = MOD_VALID ? (MOD_PAR_IN ^ (^(MOD_OLD ^ MOD_NEW))) : st_reg.mod_par;
      st_next.mem_fixed = MEM_RD_VALID ? ecc.fixed_data : st_reg.mem_fixed;

      st_next.head_discard = timeout;
      st_next.bcast_abort  = timeout && HEAD_BROADCAST;

      cur_bad = st_reg.pkt_bad || egr_perr ||
                (mem_dbl && (MEM_SEL == 3'(SIEP_BIT_IBDATA) || MEM_SEL == 3'(SIEP_BIT_EBDATA)));
      st_next.nullify         = EGR_VALID && EGR_LAST && !EGR_CONSUME && cur_bad;
      st_next.consume_discard = (EGR_VALID && EGR_LAST && EGR_CONSUME && cur_bad) ||
                                (mem_dbl && MEM_SELF_TARGET);
      st_next.flush = EGR_REPLAY && (egr_perr || mem_dbl);
      if (EGR_VALID && EGR_LAST) begin
         st_next.pkt_bad = 1'b0;
      end else begin
         st_next.pkt_bad = cur_bad;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg      <= '0;
         st_reg.mask <= SIEP_MASK_RST;
         st_reg.sev  <= SIEP_SEV_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ING_PAR           = st_reg.ing_par;
   assign ING_NAK           = st_reg.ing_nak;
   assign MOD_PAR_OUT       = st_reg.mod_par;
   assign MEM_FIXED_DATA    = st_reg.mem_fixed;
   assign HEAD_DISCARD      = st_reg.head_discard;
   assign BCAST_ABORT       = st_reg.bcast_abort;
   assign EGR_NULLIFY       = st_reg.nullify;
   assign EGR_CRC_INVERT    = st_reg.nullify;
   assign EGR_END_EDB       = st_reg.nullify;
   assign REPLAY_FLUSH      = st_reg.flush;
   assign CONSUME_DISCARD   = st_reg.consume_discard;
   assign STATUS            = st_reg.status;
   assign MASK              = st_reg.mask;
   assign SEVERITY          = st_reg.sev;
   assign AER_FIELDS        = st_reg.aer_fields;
   assign AER_UNCOR_STATUS  = st_reg.uncor;
   assign AER_COR_STATUS    = st_reg.cor;
   assign AER_HDR_LOG_VALID = st_reg.hdr_valid;
   assign AER_HDR_LOG       = st_reg.hdr;
endmodule : siep_top
`default_nettype wire

// >>> siep_top_checker.sv
// Port assertions for the internal error protection block
`timescale 1ns/10ps
`default_nettype none
module siep_top_checker
   import siep_pkg::*;
#(
   parameter longint AGE_CYCLES = SIEP_AGE_CYC,
   parameter int     AGE_W      = 40
)(
   input wire logic                 CLK,
   input wire logic                 RST_N,
   input wire logic                 REPORT_ENABLE,
   input wire logic                 AER_WR,
   input wire logic                 TEST_WR,
   input wire logic [SIEP_NSRC-1:0] TEST_DATA,
   input wire logic                 STATUS_CLR_WR,
   input wire logic                 EGR_VALID,
   input wire logic [31:0]          EGR_DATA,
   input wire logic                 EGR_PAR,
   input wire logic                 EGR_LAST,
   input wire logic                 EGR_CONSUME,
   input wire logic                 HEAD_VALID,
   input wire logic [AGE_W-1:0]     HEAD_AGE,
   input wire logic                 EGR_NULLIFY,
   input wire logic                 EGR_CRC_INVERT,
   input wire logic                 EGR_END_EDB,
   input wire logic                 HEAD_DISCARD,
   input wire logic [SIEP_NSRC-1:0] STATUS,
   input wire logic [3:0]           AER_FIELDS,
   input wire logic                 AER_UNCOR_STATUS,
   input wire logic                 AER_COR_STATUS,
   input wire logic [31:0]          AER_HDR_LOG
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence bad_last_s;
      EGR_VALID && EGR_LAST && !EGR_CONSUME && (EGR_PAR != ^EGR_DATA);
   endsequence
   sequence nullified_s;
      EGR_NULLIFY && STATUS[SIEP_BIT_END_TO_END_PARITY_ERROR];
   endsequence
   parity_nullify_a: assert property (bad_last_s |=> nullified_s)
      else $error("bad parity packet not nullified");
   nullify_form_a: assert property (EGR_NULLIFY |-> EGR_CRC_INVERT && EGR_END_EDB)
      else $error("nullify without inverted crc and edb end");
   report_gate_a: assert property (AER_UNCOR_STATUS || AER_COR_STATUS |-> $past(REPORT_ENABLE))
      else $error("report while reporting disabled");
   aer_locked_a: assert property (AER_WR && !REPORT_ENABLE |=> $stable(AER_FIELDS))
      else $error("aer fields written while disabled");
   header_ones_a: assert property (AER_UNCOR_STATUS |-> AER_HDR_LOG == SIEP_HDR_ONES)
      else $error("uncorrectable header not all ones");
   test_sets_a: assert property (TEST_WR |=> (STATUS & $past(TEST_DATA)) == $past(TEST_DATA))
      else $error("test write did not set status");
   status_sticky_a: assert property (!STATUS_CLR_WR |=> (STATUS & $past(STATUS)) == $past(STATUS))
      else $error("status bit fell without clear");
   age_discard_a: assert property (HEAD_VALID && HEAD_AGE > AGE_CYCLES |=> HEAD_DISCARD)
      else $error("aged head packet not discarded");
endmodule : siep_top_checker
bind siep_top siep_top_checker #(.AGE_CYCLES(AGE_CYCLES), .AGE_W(AGE_W)) chk_u (
   .CLK(CLK), .RST_N(RST_N), .REPORT_ENABLE(REPORT_ENABLE), .AER_WR(AER_WR), .TEST_WR(TEST_WR),
   .TEST_DATA(TEST_DATA), .STATUS_CLR_WR(STATUS_CLR_WR), .EGR_VALID(EGR_VALID), .EGR_DATA(EGR_DATA),
   .EGR_PAR(EGR_PAR), .EGR_LAST(EGR_LAST), .EGR_CONSUME(EGR_CONSUME), .HEAD_VALID(HEAD_VALID), .HEAD_AGE(HEAD_AGE),
   .EGR_NULLIFY(EGR_NULLIFY), .EGR_CRC_INVERT(EGR_CRC_INVERT), .EGR_END_EDB(EGR_END_EDB),
   .HEAD_DISCARD(HEAD_DISCARD), .STATUS(STATUS), .AER_FIELDS(AER_FIELDS),
   .AER_UNCOR_STATUS(AER_UNCOR_STATUS), .AER_COR_STATUS(AER_COR_STATUS), .AER_HDR_LOG(AER_HDR_LOG));
`default_nettype wire

// >>> siep_link_partner.sv
// Link partner model that drops nullified packets from the egress link
`timescale 1ns/10ps
`default_nettype none
module siep_link_partner (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic crc_inverted,
   input  wire logic ends_edb,
   output logic [7:0] drop_cnt_reg
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) drop_cnt_reg <= 8'h00;
      else if (crc_inverted && ends_edb) drop_cnt_reg <= drop_cnt_reg + 8'h01;
   end
endmodule : siep_link_partner
`default_nettype wire

// >>> siep_top_test.sv
// Self-checking testbench of the internal error protection block
`timescale 1ns/10ps
`default_nettype none
module siep_top_test;
   import siep_pkg::*;
   logic CLK, RST_N, REPORT_ENABLE, MASK_WR, SEV_WR, STATUS_CLR_WR, TEST_WR, AER_WR, MEM_RD_VALID;
   logic MEM_SELF_TARGET, HEAD_VALID, HEAD_BROADCAST, ING_VALID, ING_LAST, ING_LCRC_OK, EGR_VALID;
   logic EGR_PAR, EGR_LAST, EGR_REPLAY, EGR_CONSUME, MOD_VALID, MOD_PAR_IN, ING_PAR, ING_NAK, MOD_PAR_OUT;
   logic HEAD_DISCARD, BCAST_ABORT, EGR_NULLIFY, EGR_CRC_INVERT, EGR_END_EDB, REPLAY_FLUSH;
   logic CONSUME_DISCARD, AER_UNCOR_STATUS, AER_COR_STATUS, AER_HDR_LOG_VALID;
   logic [SIEP_NSRC-1:0] MASK_WDATA, SEV_WDATA, STATUS_CLR_DATA, TEST_DATA, STATUS, MASK, SEVERITY;
   logic [3:0]  AER_WDATA, AER_FIELDS;
   logic [2:0]  MEM_SEL;
   logic [6:0]  MEM_RD_CHECK;
   logic [39:0] HEAD_AGE;
   logic [31:0] MEM_RD_DATA, ING_DATA, EGR_DATA, MOD_OLD, MOD_NEW, MEM_FIXED_DATA, AER_HDR_LOG;
   logic [7:0]  drops;
   int          n_mismatch, samples_checked;
   siep_top #(.AGE_CYCLES(100)) dut_u (.*);
   siep_link_partner far_u (.clk(CLK), .rst_n(RST_N), .crc_inverted(EGR_CRC_INVERT),
                            .ends_edb(EGR_END_EDB), .drop_cnt_reg(drops));
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Ends a one-cycle request and lets its registered answer settle
   task nxt;
      @(posedge CLK);
      {MASK_WR, SEV_WR, STATUS_CLR_WR, TEST_WR, AER_WR, MEM_RD_VALID} <= '0;
      {HEAD_VALID, ING_VALID, EGR_VALID, MOD_VALID, MEM_SELF_TARGET} <= '0;
      #1;
   endtask : nxt
   task fire(input logic [6:0] d);
      @(posedge CLK);
      TEST_WR <= 1'b1;
      TEST_DATA <= d;
      nxt;
   endtask : fire
   task clr;
      @(posedge CLK);
      STATUS_CLR_WR <= 1'b1;
      STATUS_CLR_DATA <= 7'h7f;
      nxt;
   endtask : clr
   task mem(input logic [2:0] s, input logic [31:0] d);
      @(posedge CLK);
      {MEM_RD_VALID, MEM_SEL, MEM_RD_DATA} <= {1'b1, s, d};
      nxt;
   endtask : mem
   task egr(input logic [31:0] d, input logic p, input logic r, input logic c);
      @(posedge CLK);
      {EGR_VALID, EGR_LAST, EGR_DATA, EGR_PAR, EGR_REPLAY, EGR_CONSUME} <= {2'b11, d, p, r, c};
      nxt;
   endtask : egr
   task head(input logic [39:0] a, input logic b);
      @(posedge CLK);
      {HEAD_VALID, HEAD_AGE, HEAD_BROADCAST} <= {1'b1, a, b};
      nxt;
   endtask : head
   initial begin
      #2ms;
      n_mismatch++;
      wrap_up;
   end
   initial begin
      {RST_N, REPORT_ENABLE, MASK_WR, SEV_WR, STATUS_CLR_WR, TEST_WR, AER_WR, MEM_RD_VALID} = '0;
      {MEM_SELF_TARGET, HEAD_VALID, HEAD_BROADCAST, ING_VALID, ING_LAST, ING_LCRC_OK, EGR_VALID} = '0;
      {EGR_PAR, EGR_LAST, EGR_REPLAY, EGR_CONSUME, MOD_VALID, MOD_PAR_IN, HEAD_AGE} = '0;
      {MASK_WDATA, SEV_WDATA, STATUS_CLR_DATA, TEST_DATA, AER_WDATA, MEM_SEL, MEM_RD_CHECK} = '0;
      {MEM_RD_DATA, ING_DATA, EGR_DATA, MOD_OLD, MOD_NEW} = '0;
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      REPORT_ENABLE <= 1'b1;
      nxt;
      chk("status", 32'h0, STATUS);
      chk("severity", 32'h78, SEVERITY);
      chk("mask", 32'h0, MASK);
      for (int i = 0; i < SIEP_NSRC; i++) begin
         fire(7'h01 << i);
         chk("status", 32'h1 << i, STATUS);
         chk("uncor", SIEP_SEV_RST[i], AER_UNCOR_STATUS);
         chk("cor", !SIEP_SEV_RST[i], AER_COR_STATUS);
         chk("hdr valid", SIEP_SEV_RST[i], AER_HDR_LOG_VALID);
         if (SIEP_SEV_RST[i]) chk("hdr", SIEP_HDR_ONES, AER_HDR_LOG);
         clr;
         chk("status", 32'h0, STATUS);
      end
      @(posedge CLK);
      {SEV_WR, SEV_WDATA, MASK_WR, MASK_WDATA} <= {1'b1, 7'h00, 1'b1, 7'h02};
      nxt;
      chk("mask", 32'h02, MASK);
      chk("severity", 32'h00, SEVERITY);
      fire(7'h40);
      chk("cor", 32'h1, AER_COR_STATUS);
      fire(7'h02);
      chk("status", 32'h42, STATUS);
      chk("cor", 32'h0, AER_COR_STATUS);
      @(posedge CLK);
      {REPORT_ENABLE, AER_WR, AER_WDATA} <= {1'b0, 1'b1, 4'hf};
      nxt;
      chk("aer", 32'h0, AER_FIELDS);
      fire(7'h01);
      chk("cor", 32'h0, AER_COR_STATUS);
      @(posedge CLK);
      {REPORT_ENABLE, AER_WR, AER_WDATA} <= {1'b1, 1'b1, 4'ha};
      nxt;
      chk("aer", 32'ha, AER_FIELDS);
      clr;
      for (int i = 0; i < SIEP_NMEM; i++) begin
         mem(i[2:0], 32'h20);
         chk("fixed", 32'h0, MEM_FIXED_DATA);
         chk("status", 32'h1 << i, STATUS);
         clr;
      end
      mem(3'd3, 32'h3);
      chk("fixed", 32'h7, MEM_FIXED_DATA);
      egr(32'h5, ^32'h5, 1'b0, 1'b0);
      chk("nullify", 32'h1, EGR_NULLIFY);
      egr(32'h5, ^32'h5, 1'b0, 1'b0);
      chk("nullify", 32'h0, EGR_NULLIFY);
      clr;
      egr(32'h5, ~^32'h5, 1'b0, 1'b0);
      chk("crc inverted", 32'h1, EGR_CRC_INVERT);
      chk("status", 32'h40, STATUS);
      egr(32'h5, ~^32'h5, 1'b1, 1'b0);
      chk("flush", 32'h1, REPLAY_FLUSH);
      chk("drops", 32'h2, drops);
      egr(32'h5, ~^32'h5, 1'b0, 1'b1);
      chk("consume discard", 32'h1, CONSUME_DISCARD);
      @(posedge CLK);
      MEM_SELF_TARGET <= 1'b1;
      mem(3'd0, 32'h3);
      chk("consume discard", 32'h1, CONSUME_DISCARD);
      head(40'd100, 1'b0);
      chk("discard", 32'h0, HEAD_DISCARD);
      head(40'd101, 1'b1);
      chk("discard", 32'h1, HEAD_DISCARD);
      chk("abort", 32'h1, BCAST_ABORT);
      @(posedge CLK);
      {ING_VALID, ING_LAST, ING_DATA, ING_LCRC_OK} <= {2'b11, 32'h1, 1'b0};
      {MOD_VALID, MOD_OLD, MOD_NEW, MOD_PAR_IN} <= {1'b1, 32'h0, 32'h1, 1'b0};
      nxt;
      chk("ing par", 32'h1, ING_PAR);
      chk("nak", 32'h1, ING_NAK);
      chk("mod par", 32'h1, MOD_PAR_OUT);
      wrap_up;
   end
endmodule : siep_top_test
`default_nettype wire
